//--- logic/stfm_pkg.sv
// Shared constants for the terminal function mapper
`default_nettype none
package stfm_pkg;

    // Register byte offsets
    localparam logic [7:0] DI_CFG_BASE   = 8'h00;  // Eight input words, 0x00..0x1C
    localparam logic [7:0] DO_CFG_BASE   = 8'h20;  // Five output words, 0x20..0x30
    localparam logic [7:0] RESTART_OFS   = 8'h40;  // Write bit 0 to apply staged config
    localparam logic [7:0] DI_STATE_OFS  = 8'h44;  // Sensed input levels (read only)
    localparam logic [7:0] DO_STATE_OFS  = 8'h48;  // Output terminal levels (read only)
    localparam logic [7:0] EVENT_CNT_OFS = 8'h4C;  // Edge event counters (read only)

    // Input word fields: code in [5:0], contact sense in bit 8
    localparam int          DI_CODE_W  = 6;
    localparam int          DI_SENSE_B = 8;   // 1 = normally closed
    // Output word fields: code in [4:0], contact type in bit 8
    localparam int          DO_CODE_W  = 5;
    localparam int          DO_TYPE_B  = 8;   // 0 = normally closed, 1 = normally open

    localparam int          NUM_DI = 8;
    localparam int          NUM_DO = 5;       // Four general plus the alarm output

    // Reset values of the staged configuration
    localparam logic [8:0]  DI_CFG_RST = 9'h000;
    localparam logic [8:0]  DO_CFG_RST = 9'h100;
    localparam logic [8:0]  ALARM_TERM_CFG_RST = 9'h106; // Alarm terminal reports faults

    // Input function codes
    localparam logic [5:0]  FI_ALARM_RESET  = 6'h01;
    localparam logic [5:0]  FI_DEV_CLEAR    = 6'h0A;
    localparam logic [5:0]  FI_PULSE_INHIB  = 6'h0B;
    localparam logic [5:0]  FI_ESTOP        = 6'h0C;
    localparam logic [5:0]  FI_REV_INHIB    = 6'h0D;
    localparam logic [5:0]  FI_FWD_INHIB    = 6'h0E;
    localparam logic [5:0]  FI_ORIGIN       = 6'h16;
    localparam logic [5:0]  FI_JOG_FWD      = 6'h1A;
    localparam logic [5:0]  FI_JOG_REV      = 6'h1B;

    // Output function codes
    localparam logic [4:0]  FO_READY        = 5'h00;
    localparam logic [4:0]  FO_SERVO_ON     = 5'h01;
    localparam logic [4:0]  FO_ROTATION     = 5'h02;
    localparam logic [4:0]  FO_SPEED_REACH  = 5'h03;
    localparam logic [4:0]  FO_POS_REACH    = 5'h04;
    localparam logic [4:0]  FO_TORQUE_LIM   = 5'h05;
    localparam logic [4:0]  FO_FAULT        = 5'h06;
    localparam logic [4:0]  FO_BRAKE        = 5'h07;
    localparam logic [4:0]  FO_OVERLOAD     = 5'h08;
    localparam logic [4:0]  FO_SPEED_LIM    = 5'h09;
    localparam logic [4:0]  FO_DEV_WARN     = 5'h0B;
    localparam logic [4:0]  FO_HOME_DONE    = 5'h0C;
    localparam logic [4:0]  FO_DYN_BRAKE    = 5'h10;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

//--- logic/stfm_top.sv
`timescale 1ns/1ps
`default_nettype none

module stfm_top (
    input  wire logic        aclk,             // 50 MHz system clock
    input  wire logic        aresetn,          // Synchronous reset, active low
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,     // Write address
    input  wire logic        s_axi_awvalid,    // Write address valid
    output logic             s_axi_awready,    // Write address ready
    input  wire logic [31:0] s_axi_wdata,      // Write data
    input  wire logic [3:0]  s_axi_wstrb,      // Write byte strobes
    input  wire logic        s_axi_wvalid,     // Write data valid
    output logic             s_axi_wready,     // Write data ready
    output logic [1:0]       s_axi_bresp,      // Write response
    output logic             s_axi_bvalid,     // Write response valid
    input  wire logic        s_axi_bready,     // Write response ready
    input  wire logic [7:0]  s_axi_araddr,     // Read address
    input  wire logic        s_axi_arvalid,    // Read address valid
    output logic             s_axi_arready,    // Read address ready
    output logic [31:0]      s_axi_rdata,      // Read data
    output logic [1:0]       s_axi_rresp,      // Read response
    output logic             s_axi_rvalid,     // Read data valid
    input  wire logic        s_axi_rready,     // Read data ready
    // Terminals
    input  wire logic [7:0]  di_pin,           // Raw input terminals DI1..DI8
    output logic [4:0]       do_pin,           // DO1..DO4 in [3:0], alarm terminal in [4]
    // Drive state
    input  wire logic        position_mode,    // Drive is in position mode
    input  wire logic        drive_ready,      // Drive ready to run
    input  wire logic        fault_active,     // Fault condition detected
    input  wire logic        servo_on,         // Motor energised
    input  wire logic        speed_above_rot,  // Speed above rotation threshold
    input  wire logic        speed_at_target,  // Target speed reached
    input  wire logic        position_done,    // Position move complete
    input  wire logic        torque_limiting,  // Torque being limited
    input  wire logic        brake_release,    // Holding brake actuation request
    input  wire logic        overload_warn,    // Overload pre-alarm
    input  wire logic        speed_limiting,   // Speed being limited
    input  wire logic        deviation_warn,   // Deviation too large
    input  wire logic        homing_done,      // Homing complete
    input  wire logic        dyn_brake_valid,  // Dynamic brake valid
    // Function outputs
    output logic             alarm_reset_in,     // One-cycle alarm reset pulse
    output logic             deviation_clear_in, // One-cycle deviation clear pulse
    output logic             pulse_inhibit_in,   // Command pulses ignored
    output logic             emergency_stop_in,  // Emergency stop level
    output logic             reverse_inhibit_in, // Reverse motion prohibited
    output logic             forward_inhibit_in, // Forward motion prohibited
    output logic             origin_marker_in,   // One-cycle origin marker pulse
    output logic             jog_forward_in,     // Jog forward held
    output logic             jog_reverse_in      // Jog reverse held
);

    // Design notes for the next maintainer
    //
    // Two configuration copies are kept. Software writes only the staged copy,
    // so a half-written map can never steer a live terminal. A write of one to
    // bit 0 of the restart word copies both staged banks into the live banks in
    // a single cycle, which stands in for the drive restart.
    //
    // Terminal pins are asynchronous to aclk. They pass two flops before the
    // contact sense is applied, so a pin changing near a clock edge can at worst delay an edge
    // by a cycle; it never hands a metastable value to the function logic.
    //
    // Contact sense is applied before edge detection. A normally closed input
    // therefore fires its edge when the contact opens, which is what a safety
    // chain wired in series expects.
    //
    // Limitation: changing the sense of a terminal on restart may look like an
    // edge to the detector, because the previous active level was judged with
    // the old sense. Software should restart with edge terminals at rest.
    //
    // Several terminals may carry the same function. Their results are ORed,
    // so any one of two series stop switches can raise the inhibit.
    //
    // Reserved codes fall to the default branch of each decoder: inputs are
    // then ignored and outputs hold their inactive level, inverted only by a
    // normally closed contact type.
    //
    // The function outputs and terminal levels are registered, so every
    // response lags its cause by one cycle after the synchronisers.

    typedef enum {ST_IDLE, ST_BRESP} stfm_wr_state_t;

    typedef struct packed {
        logic [7:0][8:0]   di_stage;   // Staged input config, sense + code
        logic [7:0][8:0]   di_live;    // Live input config
        logic [4:0][8:0]   do_stage;   // Staged output config, type + code
        logic [4:0][8:0]   do_live;    // Live output config
        logic [7:0]        sync1;      // First synchroniser stage
        logic [7:0]        sync2;      // Second synchroniser stage
        logic [7:0]        act_prev;   // Active levels last cycle
        logic [4:0]        dout;       // Output terminal levels
        logic [8:0]        fn;         // Function outputs
        logic [7:0]        cnt_alm;    // Alarm reset edges seen
        logic [7:0]        cnt_clr;    // Deviation clear edges seen
        logic [7:0]        cnt_org;    // Origin edges seen
        stfm_wr_state_t    wst;        // Write channel state
        logic              aw_got;     // Write address held
        logic              w_got;      // Write data held
        logic [7:0]        awaddr;     // Held write address
        logic [31:0]       wdata;      // Held write data
        logic [3:0]        wstrb;      // Held strobes
        logic [1:0]        bresp;      // Write response code
        logic              rvalid;     // Read data pending
        logic [31:0]       rdata;      // Read data
        logic [1:0]        rresp;      // Read response code
    } stfm_state_t;

    stfm_state_t s_q;
    stfm_state_t s_d;

    logic [7:0] act;      // Sensed active levels after contact sense
    logic [7:0] rise;     // Active edges
    logic [8:0] fn_nxt;   // Next function outputs
    logic [4:0] do_nxt;   // Next output terminal levels
    logic [5:0] di_code;
    logic [4:0] do_code;
    logic       stat;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] rd;
    logic       rok;

    // Main next-state logic
    always_comb begin
        s_d     = s_q;
        act     = '0;
        rise    = '0;
        fn_nxt  = '0;
        do_nxt  = '0;
        di_code = '0;
        do_code = '0;
        stat    = 1'b0;
        wa      = '0;
        ra      = '0;
        rd      = '0;
        rok     = 1'b0;

        // Two flops before any logic reads the pins
        s_d.sync1 = di_pin;
        s_d.sync2 = s_q.sync1;

        // contact sense: normally closed contacts are active when open
        for (int i = 0; i < stfm_pkg::NUM_DI; i++) begin
            act[i] = s_q.sync2[i] ^ s_q.di_live[i][stfm_pkg::DI_SENSE_B];
        end
        rise       = act & ~s_q.act_prev;
        s_d.act_prev = act;

        // Several inputs may share a function; they are ORed together
        // each terminal routed by its own live code
        for (int i = 0; i < stfm_pkg::NUM_DI; i++) begin
            di_code = s_q.di_live[i][stfm_pkg::DI_CODE_W-1:0];
            case (di_code)
                stfm_pkg::FI_ALARM_RESET: fn_nxt[0] = fn_nxt[0] | rise[i];
                stfm_pkg::FI_DEV_CLEAR:   fn_nxt[1] = fn_nxt[1] | (rise[i] & position_mode);
                stfm_pkg::FI_PULSE_INHIB: fn_nxt[2] = fn_nxt[2] | (act[i] & position_mode);
                stfm_pkg::FI_ESTOP:       fn_nxt[3] = fn_nxt[3] | act[i];
                stfm_pkg::FI_REV_INHIB:   fn_nxt[4] = fn_nxt[4] | act[i];
                stfm_pkg::FI_FWD_INHIB:   fn_nxt[5] = fn_nxt[5] | act[i];
                stfm_pkg::FI_ORIGIN:      fn_nxt[6] = fn_nxt[6] | rise[i];
                stfm_pkg::FI_JOG_FWD:     fn_nxt[7] = fn_nxt[7] | act[i];
                stfm_pkg::FI_JOG_REV:     fn_nxt[8] = fn_nxt[8] | act[i];
                default: ;
            endcase
        end
        s_d.fn = fn_nxt;


        // Edge counters let software see that events fired
        // Counters wrap at 255; software must read them often enough
        if (fn_nxt[0]) s_d.cnt_alm = s_q.cnt_alm + 8'h01;
        if (fn_nxt[1]) s_d.cnt_clr = s_q.cnt_clr + 8'h01;
        if (fn_nxt[6]) s_d.cnt_org = s_q.cnt_org + 8'h01;

        // each output selects its status by its live code
        for (int j = 0; j < stfm_pkg::NUM_DO; j++) begin
            do_code = s_q.do_live[j][stfm_pkg::DO_CODE_W-1:0];
            case (do_code)
                stfm_pkg::FO_READY:       stat = drive_ready & ~fault_active;
                stfm_pkg::FO_SERVO_ON:    stat = servo_on;
                stfm_pkg::FO_ROTATION:    stat = speed_above_rot;
                stfm_pkg::FO_SPEED_REACH: stat = speed_at_target;
                stfm_pkg::FO_POS_REACH:   stat = position_done;
                stfm_pkg::FO_TORQUE_LIM:  stat = torque_limiting;
                stfm_pkg::FO_FAULT:       stat = fault_active;
                stfm_pkg::FO_BRAKE:       stat = brake_release;
                stfm_pkg::FO_OVERLOAD:    stat = overload_warn;
                stfm_pkg::FO_SPEED_LIM:   stat = speed_limiting;
                stfm_pkg::FO_DEV_WARN:    stat = deviation_warn;
                stfm_pkg::FO_HOME_DONE:   stat = homing_done;
                stfm_pkg::FO_DYN_BRAKE:   stat = dyn_brake_valid;
                default:                  stat = 1'b0;
            endcase
            // type 1 passes the status, type 0 inverts it
            do_nxt[j] = s_q.do_live[j][stfm_pkg::DO_TYPE_B] ? stat : ~stat;
        end
        s_d.dout = do_nxt;


        // Write channel: address and data taken in either order
        // The response code is computed while both halves are held, so bresp
        // is already stable on the cycle bvalid rises. Unaligned or unmapped
        // addresses give a slave error and change nothing.
        if (s_q.wst == ST_IDLE) begin
            if (s_axi_awvalid && !s_q.aw_got) begin
                s_d.aw_got = 1'b1;
                s_d.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !s_q.w_got) begin
                s_d.w_got = 1'b1;
                s_d.wdata = s_axi_wdata;
                s_d.wstrb = s_axi_wstrb;
            end
            if (s_q.aw_got && s_q.w_got) begin
                wa        = s_q.awaddr;
                s_d.bresp = stfm_pkg::RESP_OKAY;
                // writes only touch the staged copy
                if (wa[1:0] == 2'b00 && wa < stfm_pkg::DO_CFG_BASE) begin
                    if (s_q.wstrb[0]) s_d.di_stage[wa[4:2]][7:0] = s_q.wdata[7:0];
                    if (s_q.wstrb[1]) s_d.di_stage[wa[4:2]][8] = s_q.wdata[8];
                end else if (wa[1:0] == 2'b00 && wa >= stfm_pkg::DO_CFG_BASE
                             && wa <= stfm_pkg::DO_CFG_BASE + 8'h10) begin
                    if (s_q.wstrb[0]) s_d.do_stage[3'(wa[4:2])][7:0] = s_q.wdata[7:0];
                    if (s_q.wstrb[1]) s_d.do_stage[3'(wa[4:2])][8] = s_q.wdata[8];
                end else if (wa == stfm_pkg::RESTART_OFS) begin
                    // restart command makes staged config live
                    if (s_q.wstrb[0] && s_q.wdata[0]) begin
                        s_d.di_live = s_q.di_stage;
                        s_d.do_live = s_q.do_stage;
                    end
                end else if (wa != stfm_pkg::DI_STATE_OFS && wa != stfm_pkg::DO_STATE_OFS
                             && wa != stfm_pkg::EVENT_CNT_OFS) begin
                    s_d.bresp = stfm_pkg::RESP_SLVERR;
                end
                s_d.aw_got = 1'b0;
                s_d.w_got  = 1'b0;
                s_d.wst    = ST_BRESP;
            end
        end else if (s_q.wst == ST_BRESP) begin
            if (s_axi_bready) s_d.wst = ST_IDLE;
        end else begin
            s_d.wst = ST_IDLE;
        end


        // Read channel: one cycle from address to data
        // Reads of the configuration words return the staged copy, so software
        // can verify a map before it restarts. The read-only status words show
        // live values. Out-of-range reads return zero with a slave error.
        if (s_q.rvalid) begin
            if (s_axi_rready) s_d.rvalid = 1'b0;
        end else if (s_axi_arvalid) begin
            ra  = s_axi_araddr;
            rok = (ra[1:0] == 2'b00);
            if (ra < stfm_pkg::DO_CFG_BASE) begin
                rd = {23'h000000, s_q.di_stage[ra[4:2]]};
            end else if (ra <= stfm_pkg::DO_CFG_BASE + 8'h10) begin
                rd = {23'h000000, s_q.do_stage[3'(ra[4:2])]};
            end else if (ra == stfm_pkg::RESTART_OFS) begin
                rd = '0;
            end else if (ra == stfm_pkg::DI_STATE_OFS) begin
                rd = {24'h000000, act};
            end else if (ra == stfm_pkg::DO_STATE_OFS) begin
                rd = {27'h0000000, s_q.dout};
            end else if (ra == stfm_pkg::EVENT_CNT_OFS) begin
                rd = {8'h00, s_q.cnt_org, s_q.cnt_clr, s_q.cnt_alm};
            end else begin
                rok = 1'b0;
            end
            s_d.rvalid = 1'b1;
            s_d.rdata  = rok ? rd : 32'h00000000;
            s_d.rresp  = rok ? stfm_pkg::RESP_OKAY : stfm_pkg::RESP_SLVERR;
        end
    end

    // State register with synchronous reset
    // The alarm terminal alone starts on the fault code so that a fresh
    // drive reports faults before any setup.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q          <= '0;
            s_q.wst      <= ST_IDLE;
            for (int i = 0; i < stfm_pkg::NUM_DI; i++) begin
                s_q.di_stage[i] <= stfm_pkg::DI_CFG_RST;
                s_q.di_live[i]  <= stfm_pkg::DI_CFG_RST;
            end
            for (int j = 0; j < stfm_pkg::NUM_DO - 1; j++) begin
                s_q.do_stage[j] <= stfm_pkg::DO_CFG_RST;
                s_q.do_live[j]  <= stfm_pkg::DO_CFG_RST;
            end
            s_q.do_stage[4] <= stfm_pkg::ALARM_TERM_CFG_RST;
            s_q.do_live[4]  <= stfm_pkg::ALARM_TERM_CFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Handshake outputs; ready only while idle so one write at a time
    assign s_axi_awready = (s_q.wst == ST_IDLE) && !s_q.aw_got;
    assign s_axi_wready  = (s_q.wst == ST_IDLE) && !s_q.w_got;
    assign s_axi_bvalid  = (s_q.wst == ST_BRESP);
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // Registered terminal and function outputs
    assign do_pin             = s_q.dout;
    assign alarm_reset_in     = s_q.fn[0];
    assign deviation_clear_in = s_q.fn[1];
    assign pulse_inhibit_in   = s_q.fn[2];
    assign emergency_stop_in  = s_q.fn[3];
    assign reverse_inhibit_in = s_q.fn[4];
    assign forward_inhibit_in = s_q.fn[5];
    assign origin_marker_in   = s_q.fn[6];
    assign jog_forward_in     = s_q.fn[7];
    assign jog_reverse_in     = s_q.fn[8];

endmodule

`default_nettype wire

//--- tb/stfm_props.sv
`timescale 1ns/1ps
`default_nettype none
// Terminal checks that can be judged from the top ports alone
module stfm_props (
    input wire logic       aclk,               // Clock
    input wire logic       aresetn,            // Reset, active low
    input wire logic [7:0] s_axi_awaddr,       // Write address
    input wire logic       s_axi_awvalid,      // Address valid
    input wire logic       s_axi_awready,      // Address ready
    input wire logic [4:0] do_pin,             // Output terminals
    input wire logic       position_mode,      // Position mode
    input wire logic       drive_ready,        // Ready to run
    input wire logic       fault_active,       // Fault present
    input wire logic       alarm_reset_in,     // Alarm reset pulse
    input wire logic       deviation_clear_in, // Clear pulse
    input wire logic       pulse_inhibit_in,   // Pulse inhibit
    input wire logic       origin_marker_in,   // Origin pulse
    input wire logic       jog_forward_in      // Jog forward
);
    logic live_q;
    // Conservative: any restart address handshake may have moved the live map
    always_ff @(posedge aclk) begin
        if (!aresetn) live_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == stfm_pkg::RESTART_OFS) live_q <= 1'b1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    alarm_pulse_a: assert property (alarm_reset_in |=> !alarm_reset_in)
        else $error("alarm reset pulse too long");
    clear_mode_a: assert property (deviation_clear_in |-> $past(position_mode) ##1 !deviation_clear_in)
        else $error("bad deviation clear pulse");
    inhibit_mode_a: assert property (pulse_inhibit_in |-> $past(position_mode))
        else $error("pulse inhibit outside position mode");
    origin_pulse_a: assert property (origin_marker_in |=> !origin_marker_in)
        else $error("origin pulse too long");
    alarm_term_a: assert property (!live_q && $past(aresetn) |-> do_pin[4] == $past(fault_active))
        else $error("alarm terminal does not follow fault");
    ready_term_a: assert property (!live_q && do_pin[0] |-> $past(drive_ready) && !$past(fault_active))
        else $error("ready terminal without ready state");
    general_same_a: assert property (!live_q |-> do_pin[3:0] == 4'h0 || do_pin[3:0] == 4'hF)
        else $error("general terminals differ under reset map");
    staged_only_a: assert property (!live_q |-> !(jog_forward_in || pulse_inhibit_in || alarm_reset_in))
        else $error("function active before restart");
endmodule
bind stfm_top stfm_props u_props (.*);
`default_nettype wire

//--- tb/stfm_switch_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Contact bank: a closed contact pulls its terminal high
module stfm_switch_bank (
    input wire logic       aclk,   // Clock
    input wire logic [7:0] closed, // Contacts held closed
    output logic     [7:0] di_pin  // Terminal levels
);
    // Contacts move just after an edge, never mid-cycle
    always_ff @(posedge aclk) di_pin <= closed;
endmodule
`default_nettype wire

//--- tb/test_stfm_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_stfm_top;
    logic        aclk = 1'b0, aresetn = 1'b0, position_mode = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, di_pin, closed = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  do_pin;
    logic [16:0] stat = 17'h0;
    wire drive_ready = stat[0], servo_on = stat[1], speed_above_rot = stat[2], speed_at_target = stat[3],
        position_done = stat[4], torque_limiting = stat[5], fault_active = stat[6], brake_release = stat[7],
        overload_warn = stat[8], speed_limiting = stat[9], deviation_warn = stat[11], homing_done = stat[12],
        dyn_brake_valid = stat[16];
    logic alarm_reset_in, deviation_clear_in, pulse_inhibit_in, emergency_stop_in, reverse_inhibit_in;
    logic forward_inhibit_in, origin_marker_in, jog_forward_in, jog_reverse_in;
    logic [5:0] di_code [8] = '{6'h01, 6'h0A, 6'h0B, 6'h0D, 6'h0E, 6'h16, 6'h1A, 6'h1B};
    int n_mismatch = 0, checked = 0, cycles = 0;

    stfm_top DUT (.*);
    stfm_switch_bank u_sw (.aclk(aclk), .closed(closed), .di_pin(di_pin));

    initial forever #10 aclk = ~aclk;
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Address and data offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
    endtask
    task automatic restart;
        wr(stfm_pkg::RESTART_OFS, 32'h1);
        repeat (6) @(posedge aclk);
    endtask
    // Edges need a quiet gap after synchronising
    task automatic pulse(input int i);
        closed[i] <= 1'b1;
        repeat (6) @(posedge aclk);
        closed[i] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(stfm_pkg::DI_CFG_BASE, 32'h0, stfm_pkg::RESP_OKAY);
        rd_chk(stfm_pkg::DO_CFG_BASE, 32'h100, stfm_pkg::RESP_OKAY);
        rd_chk(8'h30, 32'h106, stfm_pkg::RESP_OKAY);
        rd_chk(8'h80, 32'h0, stfm_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) wr(8'(4 * i), {23'h0, i == 6, 2'b00, di_code[i]});
        pulse(0);
        rd_chk(stfm_pkg::EVENT_CNT_OFS, 32'h0, stfm_pkg::RESP_OKAY);
        // Reset map: alarm terminal follows the fault, general terminals show ready
        stat <= 17'h00040;
        repeat (3) @(posedge aclk);
        `CHK(do_pin, 5'h10)
        stat <= 17'h00000;
        repeat (3) @(posedge aclk);
        restart();
        `CHK({jog_reverse_in, jog_forward_in, forward_inhibit_in, reverse_inhibit_in, pulse_inhibit_in}, 5'b01000)
        closed <= 8'hDC;
        repeat (6) @(posedge aclk);
        `CHK({jog_reverse_in, jog_forward_in, forward_inhibit_in, reverse_inhibit_in, pulse_inhibit_in}, 5'b10111)
        position_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK({emergency_stop_in, pulse_inhibit_in, reverse_inhibit_in}, 3'b001)
        closed <= 8'h00;
        pulse(1);
        position_mode <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            pulse(0);
            pulse(1);
            pulse(5);
        end
        rd_chk(stfm_pkg::EVENT_CNT_OFS, 32'h020202, stfm_pkg::RESP_OKAY);
        // Sweep output codes 0 to 16 on an open and a closed contact
        for (int c = 0; c <= 16; c++) begin
            wr(stfm_pkg::DO_CFG_BASE, 32'h100 | 32'(c));
            wr(8'h24, 32'(c));
            restart();
            stat <= (c == 10 || (c > 12 && c < 16)) ? 17'h1FFFF : 17'h1 << c;
            repeat (3) @(posedge aclk);
            `CHK(do_pin[1:0], (c == 10 || (c > 12 && c < 16)) ? 2'b10 : 2'b01)
            stat <= 17'h0;
            repeat (3) @(posedge aclk);
            `CHK(do_pin[1:0], 2'b10)
        end
        summarize();
    end
endmodule
`default_nettype wire
